// file: src/tmc_defines.svh
// Register indices, field positions, reset values and timing counts of the timer block.
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define TMC_IDX_CTRL      8'h88
`define TMC_IDX_MODE      8'h89
`define TMC_IDX_T0_LOW    8'h8A
`define TMC_IDX_T1_LOW    8'h8B
`define TMC_IDX_T0_HIGH   8'h8C
`define TMC_IDX_T1_HIGH   8'h8D
`define TMC_IDX_IRQ_STAT  8'h98
`define TMC_IDX_IRQ_MASK  8'h99

// Control register field positions.
`define TMC_CTRL_TMR1_FLAG 7
`define TMC_CTRL_TMR1_RUN  6
`define TMC_CTRL_TMR0_FLAG 5
`define TMC_CTRL_TMR0_RUN  4

// Mode register field positions.
`define TMC_MODE_GATE_EN  3
`define TMC_MODE_CT0      2
`define TMC_MODE_SEL_HI   1
`define TMC_MODE_SEL_LO   0

// Interrupt status and mask bit positions.
`define TMC_IRQ_T0        0
`define TMC_IRQ_T1        1

// Reset values.
`define TMC_RST_BYTE      8'h00
`define TMC_RST_IRQ       2'h0

// Timer mode advances once every this many system clock cycles.
`define TMC_TICK_CYCLES   2

`endif

// file: src/tmc_pkg.sv
// Types shared by the timer block.
package tmc_pkg;

    // Timer0 counter structure selected by the mode field.
    typedef enum logic [1:0] {
        TMC_MODE_13BIT  = 2'b00,
        TMC_MODE_16BIT  = 2'b01,
        TMC_MODE_RELOAD = 2'b10,
        TMC_MODE_SPLIT  = 2'b11
    } tmc_mode_type;

endpackage

// file: src/tmc_sync.sv
// Two flip-flop synchroniser for pin inputs.
module tmc_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset.
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    // Asynchronous inputs and synchronised outputs.
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_o = stage2_reg;

endmodule

// file: src/tmc_timers.sv
// Timer0 and Timer1 counters with a classic Wishbone register slave.
// Functional notes
// - Mode 01 forms a 16-bit count; mode 10 reloads low byte from high at overflow.
// - Mode 11: low byte is an 8-bit counter with Timer0 run and flag.
// - Mode 11: high byte counts on Timer1 run bit and sets Timer1 flag.
// - Timer0 low and high bytes are read/write and reset to zero.
// - Timer1 low and high bytes are read/write and reset to zero.
// - Timer mode advances Timer0 once every two system clocks.
// - Counter mode advances Timer0 on each falling edge of its count input.
// - With gating on, Timer0 counts only while interrupt 0 input high and run set.
// - Timer0 overflow sets its flag; interrupt vectoring clears it.
//
// Local design decision: the Wishbone interface to the registers.
`include "tmc_defines.svh"

module tmc_timers
    import tmc_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    // Clock and reset.
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // Wishbone slave.
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Pins.
    input  wire logic              timer0_count_input_i,
    input  wire logic              external_interrupt0_input_i,
    // Interrupt vectoring acknowledges from the processor.
    input  wire logic              timer0_vector_ack_i,
    input  wire logic              timer1_vector_ack_i,
    // Interrupt output.
    output logic                   irq_o
);

    // Decodes a word-aligned access to one register index.
    function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [7:0] idx);
        reg_hit = (adr[1:0] == 2'b00) && (adr[ADDR_W-1:2] == idx);
    endfunction

    logic [7:0]  t0_low_reg,  t0_low_next;
    logic [7:0]  t0_high_reg, t0_high_next;
    logic [7:0]  t1_low_reg,  t1_low_next;
    logic [7:0]  t1_high_reg, t1_high_next;
    logic [7:0]  ctrl_reg,    ctrl_next;
    logic [3:0]  mode_reg,    mode_next;
    logic [1:0]  stat_reg,    stat_next;
    logic [1:0]  mask_reg,    mask_next;
    logic        div_reg,     div_next;
    logic        t0_pin_reg,  t0_pin_next;
    logic        ack_reg,     ack_next;
    logic [31:0] dat_reg,     dat_next;
    logic [1:0]  pins_sync;
    logic        t0_pin_s;
    logic        external_interrupt0_input_s;
    logic        t0_fall;
    logic        tick0;
    logic        run0;
    logic        inc_low;
    logic        ov0;
    logic        ov1;
    logic        wr_fire;
    tmc_mode_type mode0;

    // Pin inputs pass two flip-flops before any logic reads them.
    tmc_sync #(
        .WIDTH(2)
    ) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i     (rst_i),
        .async_i   ({external_interrupt0_input_i, timer0_count_input_i}),
        .sync_o    (pins_sync)
    );

    // Count enables and bus write strobe.
    assign t0_pin_s = pins_sync[0];
    assign external_interrupt0_input_s   = pins_sync[1];
    assign t0_fall  = t0_pin_reg & ~t0_pin_s;
    assign mode0    = tmc_mode_type'(mode_reg[`TMC_MODE_SEL_HI:`TMC_MODE_SEL_LO]);
    assign tick0    = mode_reg[`TMC_MODE_CT0] ? t0_fall : div_reg;
    assign run0     = ctrl_reg[`TMC_CTRL_TMR0_RUN] & (~mode_reg[`TMC_MODE_GATE_EN] | external_interrupt0_input_s);
    assign inc_low  = run0 & tick0;
    assign wr_fire  = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0];

    // Next state of counters, flags and interrupt registers.
    always_comb begin
        t0_low_next  = t0_low_reg;
        t0_high_next = t0_high_reg;
        t1_low_next  = t1_low_reg;
        t1_high_next = t1_high_reg;
        ctrl_next    = ctrl_reg;
        mode_next    = mode_reg;
        mask_next    = mask_reg;
        div_next     = ~div_reg;
        t0_pin_next  = t0_pin_s;
        ov0          = 1'b0;
        ov1          = 1'b0;
        // Timer0 low byte and the structures built on it.
        if (inc_low) begin
            case (mode0)
                TMC_MODE_13BIT: begin
                    t0_low_next[4:0] = 5'(t0_low_reg[4:0] + 5'h01);
                    if (t0_low_reg[4:0] == 5'h1F) begin
                        t0_high_next = 8'(t0_high_reg + 8'h01);
                        ov0          = (t0_high_reg == 8'hFF);
                    end
                end
                TMC_MODE_16BIT: begin
                    t0_low_next = 8'(t0_low_reg + 8'h01);
                    if (t0_low_reg == 8'hFF) begin
                        t0_high_next = 8'(t0_high_reg + 8'h01);
                        ov0          = (t0_high_reg == 8'hFF);
                    end
                end
                TMC_MODE_RELOAD: begin
                    if (t0_low_reg == 8'hFF) begin
                        t0_low_next = t0_high_reg;
                        ov0         = 1'b1;
                    end else begin
                        t0_low_next = 8'(t0_low_reg + 8'h01);
                    end
                end
                TMC_MODE_SPLIT: begin
                    t0_low_next = 8'(t0_low_reg + 8'h01);
                    ov0         = (t0_low_reg == 8'hFF);
                end
                default: begin
                    t0_low_next = t0_low_reg;
                end
            endcase
        end
        // In split mode the high byte borrows Timer1's run bit and flag.
        if (mode0 == TMC_MODE_SPLIT) begin
            if (ctrl_reg[`TMC_CTRL_TMR1_RUN] && div_reg) begin
                t0_high_next = 8'(t0_high_reg + 8'h01);
                ov1          = (t0_high_reg == 8'hFF);
            end
        end else if (ctrl_reg[`TMC_CTRL_TMR1_RUN] && div_reg) begin
            // Timer1 runs as a 16-bit timer while its run bit is its own.
            t1_low_next = 8'(t1_low_reg + 8'h01);
            if (t1_low_reg == 8'hFF) begin
                t1_high_next = 8'(t1_high_reg + 8'h01);
                ov1          = (t1_high_reg == 8'hFF);
            end
        end
        // Vectoring clears a flag.
        if (timer0_vector_ack_i) begin
            ctrl_next[`TMC_CTRL_TMR0_FLAG] = 1'b0;
        end
        if (timer1_vector_ack_i) begin
            ctrl_next[`TMC_CTRL_TMR1_FLAG] = 1'b0;
        end
        stat_next = stat_reg;
        // Software writes override the counting for this cycle.
        if (wr_fire) begin
            if (reg_hit(wb_adr_i, `TMC_IDX_T0_LOW)) begin
                t0_low_next = wb_dat_i[7:0];
            end
            if (reg_hit(wb_adr_i, `TMC_IDX_T0_HIGH)) begin
                t0_high_next = wb_dat_i[7:0];
            end
            if (reg_hit(wb_adr_i, `TMC_IDX_T1_LOW)) begin
                t1_low_next = wb_dat_i[7:0];
            end
            if (reg_hit(wb_adr_i, `TMC_IDX_T1_HIGH)) begin
                t1_high_next = wb_dat_i[7:0];
            end
            if (reg_hit(wb_adr_i, `TMC_IDX_CTRL)) begin
                ctrl_next = {wb_dat_i[7:4], 4'h0};
            end
            if (reg_hit(wb_adr_i, `TMC_IDX_MODE)) begin
                mode_next = wb_dat_i[3:0];
            end
            if (reg_hit(wb_adr_i, `TMC_IDX_IRQ_STAT)) begin
                stat_next = stat_reg & ~wb_dat_i[1:0];
            end
            if (reg_hit(wb_adr_i, `TMC_IDX_IRQ_MASK)) begin
                mask_next = wb_dat_i[1:0];
            end
        end
        // Hardware sets win over any clear in the same cycle.
        if (ov0) begin
            ctrl_next[`TMC_CTRL_TMR0_FLAG] = 1'b1;
            stat_next[`TMC_IRQ_T0]   = 1'b1;
        end
        if (ov1) begin
            ctrl_next[`TMC_CTRL_TMR1_FLAG] = 1'b1;
            stat_next[`TMC_IRQ_T1]   = 1'b1;
        end
    end

    // Registers of the counters, flags and interrupt logic.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            t0_low_reg  <= `TMC_RST_BYTE;
            t0_high_reg <= `TMC_RST_BYTE;
            t1_low_reg  <= `TMC_RST_BYTE;
            t1_high_reg <= `TMC_RST_BYTE;
            ctrl_reg    <= `TMC_RST_BYTE;
            mode_reg    <= 4'h0;
            stat_reg    <= `TMC_RST_IRQ;
            mask_reg    <= `TMC_RST_IRQ;
            div_reg     <= 1'b0;
            t0_pin_reg  <= 1'b0;
        end else begin
            t0_low_reg  <= t0_low_next;
            t0_high_reg <= t0_high_next;
            t1_low_reg  <= t1_low_next;
            t1_high_reg <= t1_high_next;
            ctrl_reg    <= ctrl_next;
            mode_reg    <= mode_next;
            stat_reg    <= stat_next;
            mask_reg    <= mask_next;
            div_reg     <= div_next;
            t0_pin_reg  <= t0_pin_next;
        end
    end

    // Bus answer: ack one cycle after the request, read data in the same register.
    always_comb begin
        ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
        dat_next = dat_reg;
        if (ack_next) begin
            dat_next = 32'h0000_0000;
            if (!wb_we_i) begin
                if (reg_hit(wb_adr_i, `TMC_IDX_T0_LOW)) begin
                    dat_next[7:0] = t0_low_reg;
                end
                if (reg_hit(wb_adr_i, `TMC_IDX_T0_HIGH)) begin
                    dat_next[7:0] = t0_high_reg;
                end
                if (reg_hit(wb_adr_i, `TMC_IDX_T1_LOW)) begin
                    dat_next[7:0] = t1_low_reg;
                end
                if (reg_hit(wb_adr_i, `TMC_IDX_T1_HIGH)) begin
                    dat_next[7:0] = t1_high_reg;
                end
                if (reg_hit(wb_adr_i, `TMC_IDX_CTRL)) begin
                    dat_next[7:0] = ctrl_reg;
                end
                if (reg_hit(wb_adr_i, `TMC_IDX_MODE)) begin
                    dat_next[3:0] = mode_reg;
                end
                if (reg_hit(wb_adr_i, `TMC_IDX_IRQ_STAT)) begin
                    dat_next[1:0] = stat_reg;
                end
                if (reg_hit(wb_adr_i, `TMC_IDX_IRQ_MASK)) begin
                    dat_next[1:0] = mask_reg;
                end
            end
        end
    end

    // Registers of the bus answer.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o    = |(stat_reg & mask_reg);

    default clocking cb @(posedge core_clk_i);
    endclocking

    // Checks of counting structures, flags and bus writes.
    mode16_carry_a: assert property (
        disable iff (rst_i)
        (inc_low && mode0 == TMC_MODE_16BIT && t0_low_reg == 8'hFF && !wr_fire)
        |=> (t0_low_reg == 8'h00) && (t0_high_reg == 8'($past(t0_high_reg) + 8'h01)))
        else $error("16-bit carry into high byte lost");
    reload_value_a: assert property (
        disable iff (rst_i)
        (inc_low && mode0 == TMC_MODE_RELOAD && t0_low_reg == 8'hFF && !wr_fire)
        |=> (t0_low_reg == $past(t0_high_reg)) && ctrl_reg[`TMC_CTRL_TMR0_FLAG])
        else $error("auto reload did not load high byte");
    split_low_a: assert property (
        disable iff (rst_i)
        (inc_low && mode0 == TMC_MODE_SPLIT && t0_low_reg == 8'hFF)
        |=> ctrl_reg[`TMC_CTRL_TMR0_FLAG])
        else $error("split low byte overflow did not set timer0 flag");
    split_high_a: assert property (
        disable iff (rst_i)
        (mode0 == TMC_MODE_SPLIT && ctrl_reg[`TMC_CTRL_TMR1_RUN] && div_reg
         && t0_high_reg == 8'hFF && !wr_fire)
        |=> ctrl_reg[`TMC_CTRL_TMR1_FLAG] && t0_high_reg == 8'h00)
        else $error("split high byte overflow did not set timer1 flag");
    t0_reset_a: assert property (
        rst_i |=> (t0_low_reg == 8'h00) && (t0_high_reg == 8'h00))
        else $error("timer0 bytes not cleared by reset");
    t1_reset_a: assert property (
        rst_i |=> (t1_low_reg == 8'h00) && (t1_high_reg == 8'h00))
        else $error("timer1 bytes not cleared by reset");
    half_rate_a: assert property (
        disable iff (rst_i)
        (!mode_reg[`TMC_MODE_CT0] && run0 && mode0 == TMC_MODE_16BIT && !wr_fire
         && t0_low_reg < 8'hFE) ##1 !wr_fire
        |=> t0_low_reg == 8'($past(t0_low_reg, 2) + 8'h01))
        else $error("timer mode not advancing once per two clocks");
    ext_edge_a: assert property (
        disable iff (rst_i)
        (mode_reg[`TMC_MODE_CT0] && run0 && mode0 == TMC_MODE_16BIT && !wr_fire)
        |=> t0_low_reg == 8'($past(t0_low_reg) + {7'h00, $past(t0_fall)}))
        else $error("counter mode mismatch with count input falling edges");
    gate_hold_a: assert property (
        disable iff (rst_i)
        (mode_reg[`TMC_MODE_GATE_EN] && !external_interrupt0_input_s && !wr_fire) |=> $stable(t0_low_reg))
        else $error("timer0 counted while gate input low");
    vector_clear_a: assert property (
        disable iff (rst_i)
        (timer0_vector_ack_i && !ov0 && !wr_fire) |=> !ctrl_reg[`TMC_CTRL_TMR0_FLAG])
        else $error("vectoring did not clear timer0 flag");
    write_wins_a: assert property (
        disable iff (rst_i)
        (wr_fire && reg_hit(wb_adr_i, `TMC_IDX_T0_LOW)) |=> t0_low_reg == $past(wb_dat_i[7:0]))
        else $error("written count byte not taken");

endmodule

// file: dv/tb.sv
// Self-checking testbench for the timer block, driven over classic Wishbone.
`include "tmc_defines.svh"

module tb;
    import tmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk_i = 1'b0;
    logic        rst_i      = 1'b1;
    logic        cyc        = 1'b0;
    logic        stb        = 1'b0;
    logic        we         = 1'b0;
    logic [9:0]  adr        = 10'h000;
    logic [3:0]  sel        = 4'h0;
    logic [31:0] dat_w      = 32'h0;
    logic [31:0] dat_r;
    logic        ack;
    logic        pin_cnt    = 1'b1;
    logic        pin_external_interrupt0_input   = 1'b0;
    logic        vack0      = 1'b0;
    logic        vack1      = 1'b0;
    logic        irq;
    int          fails      = 0;
    int          checks     = 0;
    logic [7:0]  rd;

    // Clock at 250 MHz.
    always #2 core_clk_i = ~core_clk_i;

    tmc_timers #(.ADDR_W(10)) dut (
        .core_clk_i                  (core_clk_i),
        .rst_i                       (rst_i),
        .wb_cyc_i                    (cyc),
        .wb_stb_i                    (stb),
        .wb_we_i                     (we),
        .wb_adr_i                    (adr),
        .wb_sel_i                    (sel),
        .wb_dat_i                    (dat_w),
        .wb_dat_o                    (dat_r),
        .wb_ack_o                    (ack),
        .timer0_count_input_i        (pin_cnt),
        .external_interrupt0_input_i (pin_external_interrupt0_input),
        .timer0_vector_ack_i         (vack0),
        .timer1_vector_ack_i         (vack1),
        .irq_o                       (irq)
    );

    // Compares a seen value with the expected one and reports a mismatch.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One classic Wishbone cycle; the request is held until ack is sampled high.
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        @(posedge core_clk_i);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        sel   <= 4'hF;
        adr   <= {idx, 2'b00};
        dat_w <= {24'h0, d};
        do begin
            @(posedge core_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100) begin
            fails++;
            $display("BAD bus_ack expected 1 seen timeout");
        end
        q = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    // Register write and read helpers.
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(idx, 1'b1, d, q);
    endtask

    task automatic rdreg(input logic [7:0] idx, output logic [7:0] q);
        bus(idx, 1'b0, 8'h00, q);
    endtask

    // Waits a number of clock cycles.
    task automatic cyc_wait(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // One processor vectoring pulse for the selected timer.
    task automatic vec(input logic t1);
        @(posedge core_clk_i);
        if (t1) vack1 <= 1'b1; else vack0 <= 1'b1;
        @(posedge core_clk_i);
        vack0 <= 1'b0;
        vack1 <= 1'b0;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog against a hung bus or test.
    initial begin
        cyc_wait(20000);
        fails++;
        final_report();
    end

    // Main test sequence.
    initial begin
        cyc_wait(8);
        rst_i <= 1'b0;
        // Reset values and read/write of the four count bytes.
        rdreg(`TMC_IDX_T0_LOW, rd);  chk("t0_low_rst", rd, 8'h00);
        rdreg(`TMC_IDX_T0_HIGH, rd); chk("t0_high_rst", rd, 8'h00);
        rdreg(`TMC_IDX_T1_LOW, rd);  chk("t1_low_rst", rd, 8'h00);
        rdreg(`TMC_IDX_T1_HIGH, rd); chk("t1_high_rst", rd, 8'h00);
        wr(`TMC_IDX_T0_LOW, 8'hA5);  wr(`TMC_IDX_T0_HIGH, 8'h5A);
        wr(`TMC_IDX_T1_LOW, 8'hC3);  wr(`TMC_IDX_T1_HIGH, 8'h3C);
        rdreg(`TMC_IDX_T0_LOW, rd);  chk("t0_low_rw", rd, 8'hA5);
        rdreg(`TMC_IDX_T0_HIGH, rd); chk("t0_high_rw", rd, 8'h5A);
        rdreg(`TMC_IDX_T1_LOW, rd);  chk("t1_low_rw", rd, 8'hC3);
        rdreg(`TMC_IDX_T1_HIGH, rd); chk("t1_high_rw", rd, 8'h3C);
        rdreg(8'h80, rd);            chk("unmapped", rd, 8'h00);
        $display("test registers done");
        // Timer rate: about one increment per two clocks.
        wr(`TMC_IDX_MODE, 8'h01);
        wr(`TMC_IDX_T0_LOW, 8'h00);  wr(`TMC_IDX_T0_HIGH, 8'h00);
        wr(`TMC_IDX_CTRL, 8'h10);
        cyc_wait(100);
        wr(`TMC_IDX_CTRL, 8'h00);
        rdreg(`TMC_IDX_T0_LOW, rd);  chk("rate", rd >= 8'd49 && rd <= 8'd53, 1);
        $display("test rate done");
        // 16-bit wrap, flag, status, interrupt and vectoring clear.
        wr(`TMC_IDX_T0_LOW, 8'hF0);  wr(`TMC_IDX_T0_HIGH, 8'hFF);
        wr(`TMC_IDX_IRQ_MASK, 8'h01);
        wr(`TMC_IDX_CTRL, 8'h10);
        cyc_wait(60);
        rdreg(`TMC_IDX_CTRL, rd);    chk("t0_flag_set", rd, 8'h30);
        rdreg(`TMC_IDX_T0_HIGH, rd); chk("wrap16_high", rd, 8'h00);
        chk("irq_on", irq, 1'b1);
        vec(1'b0);
        rdreg(`TMC_IDX_CTRL, rd);    chk("t0_flag_clr", rd, 8'h10);
        wr(`TMC_IDX_IRQ_STAT, 8'h01);
        cyc_wait(1);
        chk("irq_off", irq, 1'b0);
        // A write while running becomes the new count.
        wr(`TMC_IDX_T0_LOW, 8'h80);
        cyc_wait(10);
        wr(`TMC_IDX_CTRL, 8'h00);
        rdreg(`TMC_IDX_T0_LOW, rd);  chk("run_write", rd >= 8'h80 && rd <= 8'h8A, 1);
        $display("test mode16 done");
        // Auto-reload: low byte reloads from the high byte.
        wr(`TMC_IDX_MODE, 8'h02);
        wr(`TMC_IDX_T0_HIGH, 8'hC0); wr(`TMC_IDX_T0_LOW, 8'hFE);
        wr(`TMC_IDX_CTRL, 8'h10);
        cyc_wait(20);
        rdreg(`TMC_IDX_CTRL, rd);    chk("reload_flag", rd, 8'h30);
        wr(`TMC_IDX_CTRL, 8'h00);
        rdreg(`TMC_IDX_T0_HIGH, rd); chk("reload_high", rd, 8'hC0);
        rdreg(`TMC_IDX_T0_LOW, rd);  chk("reload_low", rd >= 8'hC0 && rd <= 8'hCF, 1);
        $display("test reload done");
        // Split mode: high byte runs on Timer1's run bit and flag.
        wr(`TMC_IDX_MODE, 8'h03);
        wr(`TMC_IDX_T0_LOW, 8'h00);  wr(`TMC_IDX_T0_HIGH, 8'hFE);
        wr(`TMC_IDX_IRQ_STAT, 8'h03);
        wr(`TMC_IDX_CTRL, 8'h40);
        cyc_wait(20);
        rdreg(`TMC_IDX_CTRL, rd);    chk("split_t1_flag", rd, 8'hC0);
        rdreg(`TMC_IDX_T0_LOW, rd);  chk("split_low_hold", rd, 8'h00);
        vec(1'b1);
        rdreg(`TMC_IDX_CTRL, rd);    chk("split_t1_clr", rd, 8'h40);
        wr(`TMC_IDX_T0_LOW, 8'hFC);
        wr(`TMC_IDX_CTRL, 8'h10);
        cyc_wait(20);
        rdreg(`TMC_IDX_CTRL, rd);    chk("split_t0_flag", rd, 8'h30);
        wr(`TMC_IDX_CTRL, 8'h00);
        rdreg(`TMC_IDX_T0_HIGH, rd); chk("split_high_hold", rd < 8'h20, 1);
        $display("test split done");
        // Gating: the interrupt 0 input must be high for counting.
        wr(`TMC_IDX_MODE, 8'h09);
        wr(`TMC_IDX_T0_LOW, 8'h00);  wr(`TMC_IDX_T0_HIGH, 8'h00);
        wr(`TMC_IDX_CTRL, 8'h10);
        cyc_wait(30);
        rdreg(`TMC_IDX_T0_LOW, rd);  chk("gate_low", rd, 8'h00);
        pin_external_interrupt0_input <= 1'b1;
        cyc_wait(30);
        wr(`TMC_IDX_CTRL, 8'h00);
        rdreg(`TMC_IDX_T0_LOW, rd);  chk("gate_high", rd >= 8'd10 && rd <= 8'd20, 1);
        $display("test gating done");
        // Counter mode: one step per falling edge of the count input.
        wr(`TMC_IDX_MODE, 8'h05);
        wr(`TMC_IDX_T0_LOW, 8'h00);
        wr(`TMC_IDX_CTRL, 8'h10);
        for (int i = 0; i < 5; i++) begin
            pin_cnt <= 1'b0;
            cyc_wait(4);
            pin_cnt <= 1'b1;
            cyc_wait(4);
        end
        cyc_wait(6);
        wr(`TMC_IDX_CTRL, 8'h00);
        rdreg(`TMC_IDX_T0_LOW, rd);  chk("counter_edges", rd, 8'h05);
        $display("test counter done");
        // Prescale mode: five low bits carry into the high byte.
        wr(`TMC_IDX_MODE, 8'h00);
        wr(`TMC_IDX_T0_LOW, 8'h1E);  wr(`TMC_IDX_T0_HIGH, 8'h00);
        wr(`TMC_IDX_CTRL, 8'h10);
        cyc_wait(10);
        wr(`TMC_IDX_CTRL, 8'h00);
        rdreg(`TMC_IDX_T0_HIGH, rd); chk("prescale_high", rd, 8'h01);
        $display("test prescale done");
        final_report();
    end
endmodule
